// ==== logic/hpm_map.vh ====
// constants for the hub port power and miscellaneous pin block
`ifndef HPM_MAP_VH
`define HPM_MAP_VH
// number of downstream ports
`define HPM_NUM_PORTS 4
// system clock period in ns
`define HPM_CLK_PERIOD_NS 10
// frame clock output rate in hz
`define HPM_FRAME_CLK_HZ 8000
// cycles in one half period of the frame clock (100 MHz / 16 kHz)
`define HPM_FRAME_HALF_CYC (1000000000 / (`HPM_CLK_PERIOD_NS * `HPM_FRAME_CLK_HZ * 2))
// least external reset pulse width in ns
`define HPM_RESET_MIN_NS 5000
// cycles a released combined pin needs before its read-back is trusted
`define HPM_SENSE_SETTLE 3'h4
// least reset pulse in cycles, rounded up
`define HPM_RESET_MIN_CYC ((`HPM_RESET_MIN_NS + `HPM_CLK_PERIOD_NS - 1) / `HPM_CLK_PERIOD_NS)
// reset values
`define HPM_POWER_RST 1'b0
`define HPM_SUSPEND_RST 1'b0
`define HPM_FRAME_CLK_RST 1'b0
`endif

// ==== logic/hpm_sync3.v ====
// three-stage input synchroniser with agreement filter
module hpm_sync3 #(
  parameter RST_VAL = 1'b1
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // asynchronous input
  input wire async_in,
  // filtered output
  output reg sync_out
);
  reg s1_r; // first stage, read only by s2
  reg s2_r; // second stage
  reg s3_r; // third stage

  // shift chain; output changes once stages two and three agree
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sync_out <= s3_r;
      end
    end
  end
endmodule // hpm_sync3

// ==== logic/hpm_port_power.v ====
// hub port power, over-current, suspend, frame clock and bus-power detect pins
// Function
// - power-enable output high powers port
// - low over-current input means over-current
// - combined mode: one open-drain pin does both
// - 8 kHz clock synchronised to frames
// - frame clock driven only when enabled
// - suspend output when whole hub suspended
// - suspend indication only when enabled
// - bus-power toggle renegotiates without reset
`include "hpm_map.vh"
module hpm_port_power #(
  parameter NUM_PORTS = `HPM_NUM_PORTS,
  parameter HALF_CYC = `HPM_FRAME_HALF_CYC
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // hub core requests, one bit per port
  input wire [NUM_PORTS-1:0] port_power_request,
  input wire [NUM_PORTS-1:0] port_combined_mode,
  // dedicated power-enable pins
  output reg port1_power_enable,
  output reg port2_power_enable,
  output reg port3_power_enable,
  output reg port4_power_enable,
  // dedicated over-current pins, active low
  input wire port1_overcurrent_in_n,
  input wire port2_overcurrent_in_n,
  input wire port3_overcurrent_in_n,
  input wire port4_overcurrent_in_n,
  // combined control pins, open drain
  input wire [NUM_PORTS-1:0] port_combined_control_in,
  output reg [NUM_PORTS-1:0] port_combined_control_out,
  output reg [NUM_PORTS-1:0] port_combined_control_oe,
  // over-current status to the hub core
  output reg [NUM_PORTS-1:0] port_overcurrent,
  // suspend
  input wire hub_suspended,
  input wire suspend_output_enable,
  output reg suspend_out,
  // frame clock
  input wire frame_start,
  input wire frame_clock_enable,
  output reg frame_clock_out,
  // upstream bus power
  input wire upstream_power_detect,
  output reg upstream_present,
  output reg upstream_renegotiate
);
  wire [NUM_PORTS-1:0] oc_pin_n; // dedicated pins as a vector
  wire [NUM_PORTS-1:0] oc_sync_n; // synchronised dedicated pins
  wire [NUM_PORTS-1:0] ctl_sync; // synchronised combined pins
  wire vbus_sync; // synchronised bus-power detect
  reg [NUM_PORTS-1:0] oc_nxt; // selected over-current per port
  reg [NUM_PORTS-1:0] power_nxt; // granted power per port
  reg vbus_prev_r; // last bus-power level
  reg [15:0] half_cnt_r; // half-period counter
  reg frame_clk_r; // free internal frame clock
  reg [3*NUM_PORTS-1:0] settle_cnt_r; // cycles since each combined pin was released
  reg [NUM_PORTS-1:0] sense_ok_r; // read-back of a released pin is trustworthy
  reg [NUM_PORTS-1:0] cmb_fault_r; // latched over-current on a combined pin
  reg [NUM_PORTS-1:0] cmb_trip; // released combined pin reads low now
  integer i; // port index, select logic
  integer j; // port index, settle logic

  assign oc_pin_n = {port4_overcurrent_in_n, port3_overcurrent_in_n,
                     port2_overcurrent_in_n, port1_overcurrent_in_n};

  // synchronisers for every asynchronous pin
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1) begin : g_sync
      // dedicated over-current pin
      hpm_sync3 #(.RST_VAL(1'b1)) u_oc (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(oc_pin_n[g]),
        .sync_out(oc_sync_n[g])
      );
      // combined pin read-back
      hpm_sync3 #(.RST_VAL(1'b1)) u_ctl (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(port_combined_control_in[g]),
        .sync_out(ctl_sync[g])
      );
    end
  endgenerate

  // bus-power detect pin
  hpm_sync3 #(.RST_VAL(1'b0)) u_vbus (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(upstream_power_detect),
    .sync_out(vbus_sync)
  );

  // over-current select and power grant
  always @* begin
    oc_nxt = {NUM_PORTS{1'b0}};
    power_nxt = {NUM_PORTS{1'b0}};
    cmb_trip = {NUM_PORTS{1'b0}};
    for (i = 0; i < NUM_PORTS; i = i + 1) begin
      if (port_combined_mode[i]) begin
        // only a released, settled pin that reads low is a fault;
        // our own pull-down, still in the synchroniser, is not
        cmb_trip[i] = sense_ok_r[i] & ~port_combined_control_oe[i] & ~ctl_sync[i];
        oc_nxt[i] = cmb_trip[i] | cmb_fault_r[i];
      end else begin
        oc_nxt[i] = ~oc_sync_n[i];
      end
      power_nxt[i] = port_power_request[i] & ~oc_nxt[i];
    end
  end

  // settle timer per combined pin: the read-back reaches us several cycles
  // after we let go, so the old low level must not count as a fault.
  // a combined-pin fault is held, since powering off pulls the pin low
  // and hides the monitor; the hub core retries by dropping its request.
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      settle_cnt_r <= {3*NUM_PORTS{1'b0}};
      sense_ok_r <= {NUM_PORTS{1'b0}};
      cmb_fault_r <= {NUM_PORTS{1'b0}};
    end else begin
      for (j = 0; j < NUM_PORTS; j = j + 1) begin
        if (port_combined_control_oe[j]) begin
          // pin pulled low by us: restart the timer
          settle_cnt_r[3*j +: 3] <= 3'h0;
          sense_ok_r[j] <= 1'b0;
        end else if (settle_cnt_r[3*j +: 3] != `HPM_SENSE_SETTLE) begin
          // released and still settling
          settle_cnt_r[3*j +: 3] <= settle_cnt_r[3*j +: 3] + 3'h1;
          sense_ok_r[j] <= 1'b0;
        end else begin
          // settled: read-back now shows the far side
          sense_ok_r[j] <= 1'b1;
        end
        if (cmb_trip[j]) begin
          // set wins over a clear in the same cycle
          cmb_fault_r[j] <= 1'b1;
        end else if (~port_power_request[j] | ~port_combined_mode[j]) begin
          // request withdrawn or mode left: fault forgotten
          cmb_fault_r[j] <= 1'b0;
        end
      end
    end
  end

  // pin drivers for power enable
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      port1_power_enable <= `HPM_POWER_RST;
      port2_power_enable <= `HPM_POWER_RST;
      port3_power_enable <= `HPM_POWER_RST;
      port4_power_enable <= `HPM_POWER_RST;
      port_combined_control_out <= {NUM_PORTS{1'b0}};
      port_combined_control_oe <= {NUM_PORTS{1'b1}};
      port_overcurrent <= {NUM_PORTS{1'b0}};
    end else begin
      // dedicated pins high means powered
      port1_power_enable <= power_nxt[0] & ~port_combined_mode[0];
      port2_power_enable <= power_nxt[1] & ~port_combined_mode[1];
      port3_power_enable <= power_nxt[2] & ~port_combined_mode[2];
      port4_power_enable <= power_nxt[3] & ~port_combined_mode[3];
      port_combined_control_out <= {NUM_PORTS{1'b0}};
      // open drain: release for power on, pull low for off
      port_combined_control_oe <= ~(power_nxt & port_combined_mode);
      port_overcurrent <= oc_nxt;
    end
  end

  // suspend indication
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      suspend_out <= `HPM_SUSPEND_RST;
    end else begin
      // stays low unless the indication has been enabled
      suspend_out <= hub_suspended & suspend_output_enable;
    end
  end

  // frame clock: 16 half periods per 1 ms frame, realigned on each frame start
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      half_cnt_r <= 16'h0000;
      frame_clk_r <= `HPM_FRAME_CLK_RST;
      frame_clock_out <= `HPM_FRAME_CLK_RST;
    end else begin
      if (frame_start) begin
        // rising edge lined up with the frame start
        half_cnt_r <= 16'h0000;
        frame_clk_r <= 1'b1;
      end else if (half_cnt_r == HALF_CYC[15:0] - 16'h0001) begin
        // half period done: toggle and start again
        half_cnt_r <= 16'h0000;
        frame_clk_r <= ~frame_clk_r;
      end else begin
        // free run between frame starts
        half_cnt_r <= half_cnt_r + 16'h0001;
      end
      // gate at the pin; internal clock keeps its phase while off
      frame_clock_out <= frame_clk_r & frame_clock_enable;
    end
  end

  // bus-power watch; each change asks for a new connection
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      vbus_prev_r <= 1'b0;
      upstream_present <= 1'b0;
      upstream_renegotiate <= 1'b0;
    end else begin
      // previous synchronised level for change detection
      vbus_prev_r <= vbus_sync;
      // level seen by the hub core
      upstream_present <= vbus_sync;
      // one-cycle pulse per change; no chip reset is needed to reconnect
      upstream_renegotiate <= vbus_sync ^ vbus_prev_r;
    end
  end
endmodule // hpm_port_power

// ==== bench/hpm_chk_assertions.sv ====
// checker for the port power pins
module hpm_chk (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // watched ports
  input wire [3:0] port_power_request,
  input wire [3:0] port_combined_mode,
  input wire [3:0] port_overcurrent,
  input wire port1_power_enable,
  input wire port1_overcurrent_in_n,
  input wire hub_suspended,
  input wire suspend_output_enable,
  input wire suspend_out,
  input wire frame_start,
  input wire frame_clock_enable,
  input wire frame_clock_out,
  input wire upstream_renegotiate
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ocp; port_overcurrent[0] |-> !port1_power_enable; endproperty
  a_ocp: assert property (p_ocp) else $error("power on in fault");
  property p_off; !port_power_request[0] |=> !port1_power_enable; endproperty
  a_off: assert property (p_off) else $error("power unasked");
  property p_cmb; port_combined_mode[0] |=> !port1_power_enable; endproperty
  a_cmb: assert property (p_cmb) else $error("pin in combined mode");
  property p_ocs; (!port1_overcurrent_in_n && !port_combined_mode[0]) [*7] |=> port_overcurrent[0];
  endproperty
  a_ocs: assert property (p_ocs) else $error("fault missed");
  property p_sun; hub_suspended && suspend_output_enable |=> suspend_out; endproperty
  a_sun: assert property (p_sun) else $error("no suspend");
  property p_sdis; !suspend_output_enable |=> !suspend_out; endproperty
  a_sdis: assert property (p_sdis) else $error("suspend unasked");
  property p_fsy; (frame_start && frame_clock_enable) ##1 frame_clock_enable [*2] |-> frame_clock_out;
  endproperty
  a_fsy: assert property (p_fsy) else $error("frame clock late");
  property p_fdis; !frame_clock_enable [*2] |-> !frame_clock_out; endproperty
  a_fdis: assert property (p_fdis) else $error("frame clock ungated");
  property p_rn; upstream_renegotiate |=> !upstream_renegotiate; endproperty
  a_rn: assert property (p_rn) else $error("long pulse");
endmodule // hpm_chk
bind hpm_port_power hpm_chk u_chk (.sys_clk(sys_clk), .rst(rst),
  .port_power_request(port_power_request), .port_combined_mode(port_combined_mode),
  .port_overcurrent(port_overcurrent), .port1_power_enable(port1_power_enable),
  .port1_overcurrent_in_n(port1_overcurrent_in_n), .hub_suspended(hub_suspended),
  .suspend_output_enable(suspend_output_enable), .suspend_out(suspend_out),
  .frame_start(frame_start), .frame_clock_enable(frame_clock_enable),
  .frame_clock_out(frame_clock_out), .upstream_renegotiate(upstream_renegotiate));

// ==== bench/hpm_switch_model.sv ====
// model of the external power switches and current monitors
module hpm_switch_model (
  // fault commands and pin drive
  input wire [3:0] fault,
  input wire [3:0] ctl_oe,
  input wire [3:0] ctl_out,
  // sense lines to the device
  output wire [3:0] oc_n,
  output wire [3:0] ctl_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // monitor pulls its line low on a fault
  assign oc_n = ~fault;
  // shared pin: pull-up, low when driven or faulted
  assign ctl_pin = (ctl_oe & ctl_out) | (~ctl_oe & ~fault);
endmodule // hpm_switch_model

// ==== bench/testbench.sv ====
// self-checking bench for the port power pins
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HC = 4; // shortened half period
  localparam int RST_CYC = 500; // external reset of at least 5 us at 10 ns
  logic sys_clk = 1'b0, rst = 1'b1, sus = 1'b0, sus_en = 1'b0, fs = 1'b0, fs_en = 1'b0;
  logic vbus = 1'b0, sus_o, fclk, pres, rn;
  logic [3:0] req = 4'h0, cm = 4'h0, fault = 4'h0, oc_n, pin, c_out, c_oe, oc, pe;
  int err_total = 0, n_compared = 0;
  // clock
  always #5 sys_clk = ~sys_clk;
  hpm_port_power #(.HALF_CYC(HC)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .port_power_request(req), .port_combined_mode(cm), .port1_power_enable(pe[0]),
    .port2_power_enable(pe[1]), .port3_power_enable(pe[2]), .port4_power_enable(pe[3]),
    .port1_overcurrent_in_n(oc_n[0]), .port2_overcurrent_in_n(oc_n[1]),
    .port3_overcurrent_in_n(oc_n[2]), .port4_overcurrent_in_n(oc_n[3]),
    .port_combined_control_in(pin), .port_combined_control_out(c_out),
    .port_combined_control_oe(c_oe), .port_overcurrent(oc), .hub_suspended(sus),
    .suspend_output_enable(sus_en), .suspend_out(sus_o), .frame_start(fs),
    .frame_clock_enable(fs_en), .frame_clock_out(fclk), .upstream_power_detect(vbus),
    .upstream_present(pres), .upstream_renegotiate(rn));
  hpm_switch_model sw_u (.fault(fault), .ctl_oe(c_oe), .ctl_out(c_out), .oc_n(oc_n),
    .ctl_pin(pin));
  task cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one port powered at a time
  task t_power;
    for (int i = 0; i < 4; i++) begin
      req = 4'h1 << i;
      cyc(3);
      chk("power", pe, 4'h1 << i);
    end
  endtask
  // faults on ports 1 and 2 drop their power only
  task t_oc;
    req = 4'hf;
    fault = 4'h3;
    cyc(8);
    chk("fault", oc, 4'h3);
    chk("fault power", pe, 4'hc);
    fault = 4'h0;
    cyc(8);
    chk("fault gone", oc, 4'h0);
    chk("fault gone power", pe, 4'hf);
  endtask
  // port 1 on its shared open-drain pin
  task t_comb;
    cm = 4'h1;
    cyc(3);
    chk("shared on", {pe[0], c_oe[0], 2'h0}, 4'h0);
    chk("shared drive level", c_out, 4'h0);
    fault = 4'h1;
    cyc(8);
    chk("shared fault", {oc[0], c_oe[0], 2'h0}, 4'hc);
    fault = 4'h0;
    cm = 4'h0;
    req = 4'h0;
    cyc(8);
  endtask
  // suspend indication and its enable
  task t_sus;
    sus = 1'b1;
    cyc(3);
    chk("suspend gated", {3'h0, sus_o}, 4'h0);
    sus_en = 1'b1;
    cyc(2);
    chk("suspend", {3'h0, sus_o}, 4'h1);
  endtask
  // frame clock aligned to a frame start, then gated
  task t_fclk;
    fs_en = 1'b1;
    fs = 1'b1;
    cyc(1);
    fs = 1'b0;
    cyc(2);
    chk("frame rise", {3'h0, fclk}, 4'h1);
    cyc(HC);
    chk("frame fall", {3'h0, fclk}, 4'h0);
    cyc(HC);
    fs_en = 1'b0;
    cyc(2);
    chk("frame gated", {3'h0, fclk}, 4'h0);
  endtask
  // bus-power pin toggled by the host
  task t_vbus(input logic lvl);
    vbus = lvl;
    for (int k = 0; k < 12 && rn !== 1'b1; k++) cyc(1);
    chk("renegotiate", {3'h0, rn}, 4'h1);
    cyc(2);
    chk("renegotiate pulse", {3'h0, rn}, 4'h0);
    chk("present", {3'h0, pres}, {3'h0, lvl});
  endtask
  // main sequence
  initial begin
    cyc(RST_CYC);
    rst = 1'b0;
    cyc(2);
    t_power;
    t_oc;
    t_comb;
    t_sus;
    t_fclk;
    t_vbus(1'b1);
    t_vbus(1'b0);
    wrap_up;
  end
  // watchdog, runs far past the expected few microseconds
  initial begin
    #20us;
    err_total++;
    wrap_up;
  end
endmodule // testbench
